// file: inc/regbuf_pkg.sv
package regbuf_pkg;

  // link widths
  localparam int WIDE_BITS = 25;
  localparam int NARROW_BITS = 14;

  // bit positions of the ungated control copies
  localparam int CKE_POS = 0;
  localparam int ODT_POS_A = 3;
  localparam int CS_POS = 6;
  localparam int ODT_POS_B = 10;
  localparam int CKE_POS_B = 13;

  // ungated masks per pin map
  localparam logic [24:0] KEEP_MASK_A = 25'h0000049;
  localparam logic [24:0] KEEP_MASK_B = 25'h0002440;

  // receiver wake-up after reset release
  localparam int CLK_PERIOD_NS = 40;
  localparam int RX_ACT_NS = 10;
  localparam logic [3:0] RX_ACT_CYCLES =
    4'((RX_ACT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // controller register offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] DATA_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;

  // controller field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FANOUT_BIT = 1;
  localparam int CTRL_MAP_BIT = 2;
  localparam int CTRL_RANK_CS_BIT = 3;
  localparam int STATUS_RUN_BIT = 0;
  localparam int STATUS_COUNT_LSB = 16;

  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [24:0] DATA_RESET = 25'h0000000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // operating modes, one-hot
  typedef enum logic [2:0] {
    MODE_WIDE = 3'b001,
    MODE_MAP_A = 3'b010,
    MODE_MAP_B = 3'b100
  } mode_e;

endpackage

// file: inc/regbuf_if.sv
`timescale 1ns/1ps
interface regbuf_if;
  logic [24:0] buffer_inputs;
  logic rank_chip_select;
  logic fanout_select;
  logic map_ab_select;
  logic reset_n;

  modport device (
    input buffer_inputs,
    input rank_chip_select,
    input fanout_select,
    input map_ab_select,
    input reset_n
  );

  modport host (
    output buffer_inputs,
    output rank_chip_select,
    output fanout_select,
    output map_ab_select,
    output reset_n
  );
endinterface

// file: logic/regbuf_device.sv
`timescale 1ns/1ps
module regbuf_device (
  // clock
  input wire logic hclk,
  // link from the controller
  regbuf_if.device link,
  // outputs toward the memory loads
  output logic [24:0] out_a,
  output logic [13:0] out_b
);
  import regbuf_pkg::*;

  logic [3:0] rx_count;
  logic rx_ready;
  mode_e mode;
  logic gate;
  logic [24:0] captured;
  logic [24:0] hold_mask;
  logic [24:0] next_a;
  logic [13:0] next_b;

  // receiver wake-up counter, restarted by every reset
  always_ff @(posedge hclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      rx_count <= 4'h0;
    end else if (rx_count != RX_ACT_CYCLES) begin
      rx_count <= rx_count + 4'h1;
    end
  end

  assign rx_ready = (rx_count == RX_ACT_CYCLES);

  // inputs read as low while receivers wake, so no glitch escapes
  assign captured = rx_ready ? link.buffer_inputs : 25'h0000000;

  // both selects high suspend the gated bits; grounded rank select never gates
  assign gate = link.buffer_inputs[CS_POS] & link.rank_chip_select;

  // mode decode from the strapped configuration pins
  always_comb begin
    if (!link.fanout_select) begin
      mode = MODE_WIDE;
    end else if (!link.map_ab_select) begin
      mode = MODE_MAP_A;
    end else begin
      mode = MODE_MAP_B;
    end
  end

  // next output values per pin map
  always_comb begin
    hold_mask = 25'h0000000;
    next_a = 25'h0000000;
    next_b = 14'h0000;
    case (mode)
      MODE_WIDE: begin
        hold_mask = gate ? ~KEEP_MASK_A : 25'h0000000;
        next_a = (captured & ~hold_mask) | (out_a & hold_mask);
        next_b = 14'h0000;
      end
      MODE_MAP_A: begin
        hold_mask = gate ? ~KEEP_MASK_A : 25'h0000000;
        next_a[13:0] = (captured[13:0] & ~hold_mask[13:0]) |
                       (out_a[13:0] & hold_mask[13:0]);
        next_b = next_a[13:0];
      end
      MODE_MAP_B: begin
        hold_mask = gate ? ~KEEP_MASK_B : 25'h0000000;
        next_a[13:0] = (captured[13:0] & ~hold_mask[13:0]) |
                       (out_a[13:0] & hold_mask[13:0]);
        next_b = next_a[13:0];
      end
      default: begin
        next_a = 25'h0000000;
        next_b = 14'h0000;
      end
    endcase
  end

  // output registers; upper positions stay low in the 1:2 maps
  always_ff @(posedge hclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      out_a <= 25'h0000000;
      out_b <= 14'h0000;
    end else begin
      out_a <= next_a;
      out_b <= next_b;
    end
  end

endmodule

// file: logic/regbuf_host.sv
// The implementer's own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
module regbuf_host (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // link to the buffer
  regbuf_if.host link
);
  import regbuf_pkg::*;

  logic [3:0] ctrl;
  logic [24:0] data;
  logic [15:0] count;
  logic wr_pending;
  logic [7:0] wr_addr;
  logic rd_take;
  logic [31:0] next_rdata;

  // address phase capture for writes; zero wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pending <= hsel & htrans[1] & hready & hwrite;
      wr_addr <= haddr[7:0];
    end
  end

  assign rd_take = hsel & htrans[1] & hready & ~hwrite;

  // fanout and map configuration changes only while the buffer is held in reset; run and rank select always writable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= CTRL_RESET;
    end else if (wr_pending && wr_addr == CTRL_OFF) begin
      if (!ctrl[CTRL_RUN_BIT]) begin
        ctrl <= hwdata[3:0];
      end else begin
        ctrl[CTRL_RUN_BIT] <= hwdata[CTRL_RUN_BIT];
        ctrl[CTRL_RANK_CS_BIT] <= hwdata[CTRL_RANK_CS_BIT];
      end
    end
  end

  // data word and issued-word count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data <= DATA_RESET;
      count <= COUNT_RESET;
    end else if (wr_pending && wr_addr == DATA_OFF) begin
      data <= hwdata[24:0];
      count <= count + 16'h0001;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    if (haddr[7:0] == CTRL_OFF) begin
      next_rdata = {28'h0000000, ctrl};
    end else if (haddr[7:0] == DATA_OFF) begin
      next_rdata = {7'h00, data};
    end else if (haddr[7:0] == STATUS_OFF) begin
      next_rdata = {count, 15'h0000, ctrl[CTRL_RUN_BIT]};
    end else begin
      next_rdata = 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= next_rdata;
    end
  end

  // link pins always driven to valid levels from flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link.reset_n <= 1'b0;
      link.fanout_select <= 1'b0;
      link.map_ab_select <= 1'b0;
      link.rank_chip_select <= 1'b0;
      link.buffer_inputs <= DATA_RESET;
    end else begin
      link.reset_n <= ctrl[CTRL_RUN_BIT];
      link.fanout_select <= ctrl[CTRL_FANOUT_BIT];
      link.map_ab_select <= ctrl[CTRL_MAP_BIT];
      link.rank_chip_select <= ctrl[CTRL_RANK_CS_BIT];
      link.buffer_inputs <= ctrl[CTRL_RUN_BIT] ? data : DATA_RESET;
    end
  end

  // bus answer from flops: never waits, never errors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

endmodule

// file: tb/regbuf_checker.sv
`timescale 1ns/1ps
module regbuf_checker (
  // clock
  input wire logic hclk,
  // link
  input wire logic [24:0] buffer_inputs,
  input wire logic rank_chip_select,
  input wire logic fanout_select,
  input wire logic map_ab_select,
  input wire logic reset_n,
  // buffer outputs
  input wire logic [24:0] out_a,
  input wire logic [13:0] out_b
);
  import regbuf_pkg::*;
  // first edge after release only flushes zeros, so it is no capture
  logic was_up;
  always_ff @(posedge hclk or negedge reset_n) begin
    if (!reset_n) was_up <= 1'h0;
    else was_up <= 1'h1;
  end
  // capture, gating and ungated mask
  wire logic cap = reset_n && was_up;
  wire logic gate = buffer_inputs[6] && rank_chip_select;
  wire logic [24:0] keep = (fanout_select && map_ab_select) ? KEEP_MASK_B : KEEP_MASK_A;
  wire logic [24:0] pair_in = {11'h0, buffer_inputs[13:0]};
  default clocking @(posedge hclk); endclocking
  default disable iff (!reset_n);
  AST_RESET_LOW: assert property (
    disable iff (1'h0) !reset_n |-> !out_a && !out_b)
    else $error("outputs not low in reset");
  AST_WIDE_PASS: assert property (
    cap && !fanout_select && !gate |=> out_a == $past(buffer_inputs))
    else $error("wide output not captured");
  AST_WIDE_SPARE: assert property (!fanout_select |-> out_b == 14'h0)
    else $error("spare copies not low");
  AST_PAIR_COPY: assert property (
    fanout_select |-> out_a[13:0] == out_b && !out_a[24:14])
    else $error("copies differ or unused high");
  AST_PAIR_PASS: assert property (
    cap && fanout_select && !gate |=> out_a == $past(pair_in))
    else $error("pair output not captured");
  AST_GATE_HOLD: assert property (
    cap && gate |=> !((out_a ^ $past(out_a)) & ~$past(keep)))
    else $error("gated bits changed");
  AST_KEEP_MOVE: assert property (
    cap && gate |=> (out_a & $past(keep)) == ($past(buffer_inputs) & $past(keep)))
    else $error("control copies frozen");
  AST_WAKE_LOW: assert property (
    $rose(reset_n) |-> !out_a ##1 !out_a && !out_b)
    else $error("output glitch on wake");
endmodule

// file: tb/configurable_dimm_register_buffer_tb_top.sv
`timescale 1ns/1ps
module configurable_dimm_register_buffer_tb_top;
  import regbuf_pkg::*;
  // bus side stimulus and results
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdata;
  logic hreadyout, hresp;
  logic [24:0] out_a;
  logic [13:0] out_b;
  int fail_count = 0, checks_done = 0, ndata = 0;
  regbuf_if link_if();
  regbuf_host regbuf_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link_if.host));
  regbuf_device regbuf_device_inst (.hclk(hclk), .link(link_if.device), .out_a(out_a),
    .out_b(out_b));
  regbuf_checker regbuf_checker_inst (.hclk(hclk), .buffer_inputs(link_if.buffer_inputs),
    .rank_chip_select(link_if.rank_chip_select), .fanout_select(link_if.fanout_select),
    .map_ab_select(link_if.map_ab_select), .reset_n(link_if.reset_n), .out_a(out_a),
    .out_b(out_b));
  // 25 MHz clock
  always #20 hclk = ~hclk;
  // one single word transfer, waiting on hready in both phases
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rdata = hrdata;
  endtask
  task automatic chk_reg(input logic [31:0] exp);
    checks_done++;
    if (rdata !== exp || hresp !== 1'h0) begin
      fail_count++;
      $display("wrong value at %0t: read %h not %h", $time, rdata, exp);
    end
  endtask
  // sampled mid-cycle so the edge updates have landed
  task automatic chk_out(input logic [24:0] p, input logic f);
    @(negedge hclk);
    checks_done++;
    if ({out_b, out_a} !== (f ? {p[13:0], 11'h0, p[13:0]} : {14'h0, p})) begin
      fail_count++;
      $display("wrong value at %0t: outputs %h", $time, {out_b, out_a});
    end
  endtask
  // reset values and an unmapped place
  task automatic t_regs;
    ahb(8'h0C, 1'h1, 32'hFFFFFFFF);
    ahb(8'h0C, 1'h0, 32'h0);
    chk_reg(32'h0);
    ahb(CTRL_OFF, 1'h0, 32'h0);
    chk_reg(32'h0);
    ahb(STATUS_OFF, 1'h0, 32'h0);
    chk_reg(32'h0);
  endtask
  // mode set under reset, then plain, gated and released captures
  task automatic t_mode(input logic [1:0] cfg, input logic [24:0] p1, input logic [24:0] p2);
    logic [24:0] m;
    m = (cfg == 2'h3) ? KEEP_MASK_B : KEEP_MASK_A;
    ahb(CTRL_OFF, 1'h1, 32'h0);
    // the link reset flop follows the control word one edge later
    @(posedge hclk);
    chk_out(25'h0, 1'h0);
    ahb(CTRL_OFF, 1'h1, {29'h0, cfg, 1'h0});
    ahb(CTRL_OFF, 1'h1, {29'h0, cfg, 1'h1});
    ahb(DATA_OFF, 1'h1, {7'h0, p1});
    repeat (4) @(posedge hclk);
    chk_out(p1, cfg[0]);
    ahb(CTRL_OFF, 1'h1, {29'h1, cfg, 1'h1});
    ahb(DATA_OFF, 1'h1, {7'h0, p2});
    repeat (4) @(posedge hclk);
    chk_out((p1 & ~m) | (p2 & m), cfg[0]);
    ahb(CTRL_OFF, 1'h1, {29'h0, cfg, 1'h1});
    repeat (4) @(posedge hclk);
    chk_out(p2, cfg[0]);
    ndata += 2;
  endtask
  // mode change refused while running, write count kept
  task automatic t_refuse;
    ahb(CTRL_OFF, 1'h1, 32'h1);
    ahb(CTRL_OFF, 1'h0, 32'h0);
    chk_reg(32'h7);
    ahb(STATUS_OFF, 1'h0, 32'h0);
    chk_reg({ndata[15:0], 16'h1});
    ahb(DATA_OFF, 1'h0, 32'h0);
    chk_reg({7'h0, 25'h0A5C3FD});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'h1;
    t_regs();
    t_mode(2'h0, 25'h1B5A4B2, 25'h0A5C3FD);
    t_mode(2'h1, 25'h1B5A4B2, 25'h0A5C3FD);
    t_mode(2'h3, 25'h1B5A4B2, 25'h0A5C3FD);
    t_refuse();
    end_sim();
  end
  // hang guard, far beyond the expected run
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
endmodule
